// ==== src/hbd_pkg.sv ====
// Purpose: shared constants and types for the h-bridge drive logic
// Assumes: one 8-bit control/status register behind an AXI4-Lite slave
// Notes: register index 0x21 sits at byte address 4 * index
package hbd_pkg;

  // bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  CSR_INDEX     = 8'h21;
  localparam logic [7:0]  CSR_ADDR      = CSR_INDEX << 2;
  localparam logic [7:0]  CSR_RESET     = 8'h00;

  // field positions of bridge_ctrl_status
  localparam int          BIT_ENABLE    = 0;
  localparam int          BIT_PULSE_EN  = 1;
  localparam int          BIT_LEFT_CMD  = 2;
  localparam int          BIT_RIGHT_CMD = 3;
  localparam int          BIT_DIR       = 4;
  localparam int          BIT_SHORT     = 5;
  localparam int          BIT_HEAT      = 6;
  localparam int          BIT_IRQ_EN    = 7;

  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // gate vector order: left high, left low, right high, right low
  localparam int          GATE_LH       = 3;
  localparam int          GATE_LL       = 2;
  localparam int          GATE_RH       = 1;
  localparam int          GATE_RL       = 0;
  localparam logic [3:0]  GATES_OFF     = 4'h0;

  // pulse-drive mode, selected by {left_cmd_bit, right_cmd_bit}
  typedef enum logic [1:0] {
    HBD_MODE_UP_BRAKE   = 2'h0,
    HBD_MODE_DOWN_BRAKE = 2'h1,
    HBD_MODE_SYMMETRIC  = 2'h2,
    HBD_MODE_DUAL       = 2'h3
  } hbd_mode_e;

endpackage : hbd_pkg

// ==== src/hbd_drive_if.sv ====
// Purpose: settings to the gate decoder and decoded gates back
// Assumes: all signals on ref_clk
// Notes: gate_next is combinational, registered by the top
`timescale 1ns/100ps
interface hbd_drive_if;
  logic       bridge_en;
  logic       pulse_drive_en;
  logic       left_cmd_bit;
  logic       right_cmd_bit;
  logic       dir_bit;
  logic       fault_hold;
  logic       first_pulse_line;
  logic       second_pulse_line;
  logic [3:0] gate_next;

  modport ctrl (
    output bridge_en, pulse_drive_en, left_cmd_bit, right_cmd_bit,
    output dir_bit, fault_hold, first_pulse_line, second_pulse_line,
    input  gate_next
  );
  modport dec (
    input  bridge_en, pulse_drive_en, left_cmd_bit, right_cmd_bit,
    input  dir_bit, fault_hold, first_pulse_line, second_pulse_line,
    output gate_next
  );
endinterface : hbd_drive_if

// ==== src/hbd_gate_decode.sv ====
// Purpose: direction latch and gate decode for all drive modes
// Assumes: pulse lines come from on-chip generators on ref_clk
// Notes: a gate value of 1 means transistor on
`timescale 1ns/100ps
module hbd_gate_decode
  import hbd_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // settings and gates
  hbd_drive_if.dec  drv
);

  logic      first_prev_reg;
  logic      second_prev_reg;
  logic      dir_eff_reg;
  logic      first_rise;
  logic      second_rise;
  logic      latch_now;
  logic      dir_use;
  hbd_mode_e mode;

  assign mode        = hbd_mode_e'({drv.left_cmd_bit, drv.right_cmd_bit});
  assign first_rise  = drv.first_pulse_line & ~first_prev_reg;
  assign second_rise = drv.second_pulse_line & ~second_prev_reg;
  // no edge at 0% or 100% duty, so the old direction stays
  assign latch_now   = drv.pulse_drive_en &
                       (first_rise | (mode == HBD_MODE_DUAL && second_rise));
  assign dir_use     = latch_now ? drv.dir_bit : dir_eff_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_prev_reg  <= 1'b0;
      second_prev_reg <= 1'b0;
    end else begin
      first_prev_reg  <= drv.first_pulse_line;
      second_prev_reg <= drv.second_pulse_line;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dir_eff_reg <= 1'b0;
    end else if (latch_now) begin
      dir_eff_reg <= drv.dir_bit;
    end
  end

  always_comb begin
    logic p1;
    logic p2;
    p1            = drv.first_pulse_line;
    p2            = drv.second_pulse_line;
    drv.gate_next = GATES_OFF;
    if (!drv.bridge_en || drv.fault_hold) begin
      drv.gate_next = GATES_OFF;
    end else if (!drv.pulse_drive_en) begin
      // direct mode, direction has no effect
      drv.gate_next[GATE_LH] = drv.left_cmd_bit;
      drv.gate_next[GATE_LL] = ~drv.left_cmd_bit;
      drv.gate_next[GATE_RH] = drv.right_cmd_bit;
      drv.gate_next[GATE_RL] = ~drv.right_cmd_bit;
    end else begin
      unique case (mode)
        HBD_MODE_UP_BRAKE, HBD_MODE_DOWN_BRAKE: begin
          if (!p1) begin
            if (mode == HBD_MODE_UP_BRAKE) begin
              drv.gate_next = 4'hA;
            end else begin
              drv.gate_next = 4'h5;
            end
          end else if (!dir_use) begin
            drv.gate_next = 4'h9;
          end else begin
            drv.gate_next = 4'h6;
          end
        end
        HBD_MODE_SYMMETRIC: begin
          if (p1 == ~dir_use) begin
            drv.gate_next = 4'h9;
          end else begin
            drv.gate_next = 4'h6;
          end
        end
        HBD_MODE_DUAL: begin
          drv.gate_next = {p1, ~p1, p2, ~p2};
        end
      endcase
    end
  end

endmodule : hbd_gate_decode

// ==== src/hbd_bridge_top.sv ====
// Purpose: h-bridge drive mode logic with AXI4-Lite register access
// Assumes: pulse lines on ref_clk; fault inputs asynchronous
`timescale 1ns/100ps
module hbd_bridge_top
  import hbd_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // on-chip pulse generators
  input  wire logic              first_pulse_line,
  input  wire logic              second_pulse_line,
  // fault detectors
  input  wire logic              short_fault_in,
  input  wire logic              heat_fault_in,
  // gate drives
  output logic                   left_high_gate,
  output logic                   left_low_gate,
  output logic                   right_high_gate,
  output logic                   right_low_gate,
  // fault interrupt request
  output logic                   fault_irq
);

  // control bits held by software, and the interrupt enable history
  logic              bridge_en_reg;
  logic              pulse_drive_en_reg;
  logic              left_cmd_bit_reg;
  logic              right_cmd_bit_reg;
  logic              dir_bit_reg;
  logic              bridge_irq_enable_reg;
  logic              irq_en_prev_reg;

  // fault path
  logic              short_meta_reg;
  logic              short_sync_reg;
  logic              heat_meta_reg;
  logic              heat_sync_reg;
  logic              short_fault_flag_reg;
  logic              heat_fault_flag_reg;
  logic              short_set;
  logic              heat_set;
  logic              short_fault_flag_next;
  logic              heat_fault_flag_next;
  logic              irq_set;
  logic              irq_next;
  logic              short_rise;
  logic              heat_rise;
  logic              arm_rise;

  // bus slave state
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0]        wdata_reg;
  logic              wstrb_reg;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              b_hs;
  logic              r_hs;
  logic              do_write;
  logic              csr_write;
  logic [7:0]        csr_value;
  logic              aw_mapped;
  logic              ar_mapped;
  logic [DATA_W-1:0] rdata_next;
  logic [1:0]        rresp_next;

  hbd_drive_if drv ();

  // bus handshakes
  assign aw_hs     = s_axi_awvalid & s_axi_awready;
  assign w_hs      = s_axi_wvalid & s_axi_wready;
  assign ar_hs     = s_axi_arvalid & s_axi_arready;
  assign b_hs      = s_axi_bvalid & s_axi_bready;
  assign r_hs      = s_axi_rvalid & s_axi_rready;
  assign do_write  = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign aw_mapped = (awaddr_reg == CSR_ADDR);
  assign ar_mapped = (s_axi_araddr == CSR_ADDR);
  assign csr_write = do_write & wstrb_reg & aw_mapped;

  // register image as software sees it
  assign csr_value = {bridge_irq_enable_reg, heat_fault_flag_reg,
                      short_fault_flag_reg, dir_bit_reg, right_cmd_bit_reg,
                      left_cmd_bit_reg, pulse_drive_en_reg, bridge_en_reg};

  // write address channel
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      aw_held_reg   <= 1'b0;
      awaddr_reg    <= '0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
      end else begin
        if (do_write) begin
          aw_held_reg <= 1'b0;
        end
        if (!aw_held_reg && !s_axi_bvalid) begin
          s_axi_awready <= 1'b1;
        end
      end
    end
  end

  // write data channel, only byte lane 0 carries register bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_wready <= 1'b0;
      w_held_reg   <= 1'b0;
      wdata_reg    <= 8'h00;
      wstrb_reg    <= 1'b0;
    end else begin
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata[7:0];
        wstrb_reg    <= s_axi_wstrb[0];
      end else begin
        if (do_write) begin
          w_held_reg <= 1'b0;
        end
        if (!w_held_reg && !s_axi_bvalid) begin
          s_axi_wready <= 1'b1;
        end
      end
    end
  end

  // write response, unmapped address answers slverr
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (b_hs) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read answer for the address on offer, zero and slverr when unmapped
  always_comb begin
    rdata_next = '0;
    rresp_next = RESP_SLVERR;
    if (ar_mapped) begin
      rdata_next = {24'h000000, csr_value};
      rresp_next = RESP_OKAY;
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdata_next;
      s_axi_rresp   <= rresp_next;
    end else if (r_hs) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // software-writable bits; flag positions are not stored here
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bridge_en_reg         <= CSR_RESET[BIT_ENABLE];
      pulse_drive_en_reg    <= CSR_RESET[BIT_PULSE_EN];
      left_cmd_bit_reg      <= CSR_RESET[BIT_LEFT_CMD];
      right_cmd_bit_reg     <= CSR_RESET[BIT_RIGHT_CMD];
      dir_bit_reg           <= CSR_RESET[BIT_DIR];
      bridge_irq_enable_reg <= CSR_RESET[BIT_IRQ_EN];
    end else if (csr_write) begin
      bridge_en_reg         <= wdata_reg[BIT_ENABLE];
      pulse_drive_en_reg    <= wdata_reg[BIT_PULSE_EN];
      left_cmd_bit_reg      <= wdata_reg[BIT_LEFT_CMD];
      right_cmd_bit_reg     <= wdata_reg[BIT_RIGHT_CMD];
      dir_bit_reg           <= wdata_reg[BIT_DIR];
      bridge_irq_enable_reg <= wdata_reg[BIT_IRQ_EN];
    end
  end

  // short-circuit input through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      short_meta_reg <= 1'b0;
      short_sync_reg <= 1'b0;
    end else begin
      short_meta_reg <= short_fault_in;
      short_sync_reg <= short_meta_reg;
    end
  end

  // overtemperature input through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      heat_meta_reg  <= 1'b0;
      heat_sync_reg  <= 1'b0;
    end else begin
      heat_meta_reg  <= heat_fault_in;
      heat_sync_reg  <= heat_meta_reg;
    end
  end

  // flags set only while enabled; enable low clears them, even with a fault present
  assign short_set             = short_sync_reg & bridge_en_reg;
  assign heat_set              = heat_sync_reg & bridge_en_reg;
  assign short_fault_flag_next = short_set | (short_fault_flag_reg & bridge_en_reg);
  assign heat_fault_flag_next  = heat_set | (heat_fault_flag_reg & bridge_en_reg);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      short_fault_flag_reg <= 1'b0;
    end else begin
      short_fault_flag_reg <= short_fault_flag_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      heat_fault_flag_reg  <= 1'b0;
    end else begin
      heat_fault_flag_reg  <= heat_fault_flag_next;
    end
  end

  // interrupt request: flag rise, or enable rise over a standing flag
  assign short_rise = short_set & ~short_fault_flag_reg;
  assign heat_rise  = heat_set & ~heat_fault_flag_reg;
  assign arm_rise   = bridge_irq_enable_reg & ~irq_en_prev_reg;
  // no new request once enable is low, even with a flag not yet cleared
  assign irq_set    = bridge_irq_enable_reg & bridge_en_reg &
                      (short_rise | heat_rise |
                       (arm_rise & (short_fault_flag_reg | heat_fault_flag_reg)));
  assign irq_next   = irq_set | (fault_irq & bridge_en_reg);

  // enable history, for the rise of the interrupt enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_en_prev_reg <= 1'b0;
    end else begin
      irq_en_prev_reg <= bridge_irq_enable_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_irq <= 1'b0;
    end else begin
      fault_irq <= irq_next;
    end
  end

  // settings to the decoder
  assign drv.bridge_en         = bridge_en_reg;
  assign drv.pulse_drive_en    = pulse_drive_en_reg;
  assign drv.left_cmd_bit      = left_cmd_bit_reg;
  assign drv.right_cmd_bit     = right_cmd_bit_reg;
  assign drv.dir_bit           = dir_bit_reg;
  assign drv.fault_hold        = short_set | heat_set |
                                 short_fault_flag_reg | heat_fault_flag_reg;
  assign drv.first_pulse_line  = first_pulse_line;
  assign drv.second_pulse_line = second_pulse_line;

  hbd_gate_decode u_decode (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .drv     (drv)
  );

  // gates leave through flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      left_high_gate  <= 1'b0;
      left_low_gate   <= 1'b0;
      right_high_gate <= 1'b0;
      right_low_gate  <= 1'b0;
    end else begin
      left_high_gate  <= drv.gate_next[GATE_LH];
      left_low_gate   <= drv.gate_next[GATE_LL];
      right_high_gate <= drv.gate_next[GATE_RH];
      right_low_gate  <= drv.gate_next[GATE_RL];
    end
  end

endmodule : hbd_bridge_top

// ==== tb/hbd_bridge_top_asserts.sv ====
// Purpose: port-level checks for the h-bridge drive logic
// Assumes: one write and one read in flight at a time
// Notes: bound to the top from the testbench file
`timescale 1ns/100ps
module hbd_bridge_checker
  import hbd_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rstn,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  // faults, gates, request
  input wire logic              short_fault_in,
  input wire logic              heat_fault_in,
  input wire logic              left_high_gate,
  input wire logic              left_low_gate,
  input wire logic              right_high_gate,
  input wire logic              right_low_gate,
  input wire logic              fault_irq
);
  logic exp_ok_reg;
  logic any_gate;

  // expected write response, latched when the address is taken
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      exp_ok_reg <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      exp_ok_reg <= (s_axi_awaddr == CSR_ADDR);
  end
  assign any_gate = left_high_gate || left_low_gate || right_high_gate || right_low_gate;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_reset_gates_off: assert property ($rose(rstn) |-> !any_gate)
    else $error("gates on right after reset");
  a_fault_gates_off: assert property ((short_fault_in || heat_fault_in) [*3] |=> !any_gate)
    else $error("gates on while a fault is present");
  a_left_exclusive: assert property (!(left_high_gate && left_low_gate))
    else $error("left half with both gates on");
  a_right_exclusive: assert property (!(right_high_gate && right_low_gate))
    else $error("right half with both gates on");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    s_axi_rresp == (($past(s_axi_araddr) == CSR_ADDR) ? RESP_OKAY : RESP_SLVERR))
    else $error("read response wrong or late");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rdata_unmapped: assert property (s_axi_rvalid && s_axi_rresp != RESP_OKAY |-> s_axi_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_write_resp: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (exp_ok_reg ? RESP_OKAY : RESP_SLVERR))
    else $error("write response code wrong");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");

  c_irq: cover property (fault_irq);
  c_slverr: cover property ($rose(s_axi_bvalid) && !exp_ok_reg);
  c_back: cover property (left_low_gate && right_high_gate);
endmodule : hbd_bridge_checker

// ==== tb/hbd_gate_partner.sv ====
// Purpose: behavioural model of the four gate drivers and bridge outputs
// Assumes: gate value 1 turns a transistor on
// Notes: an output with no transistor on floats; both on is unknown
`timescale 1ns/100ps
module hbd_gate_partner (
  // gates
  input  wire logic left_high_gate,
  input  wire logic left_low_gate,
  input  wire logic right_high_gate,
  input  wire logic right_low_gate,
  // outputs
  output logic      left_output,
  output logic      right_output
);
  assign left_output = (left_high_gate && left_low_gate) ? 1'bx : left_high_gate ? 1'b1 :
                       left_low_gate ? 1'b0 : 1'bz;
  assign right_output = (right_high_gate && right_low_gate) ? 1'bx : right_high_gate ? 1'b1 :
                        right_low_gate ? 1'b0 : 1'bz;
endmodule : hbd_gate_partner

// ==== tb/tb_hbd_bridge_top.sv ====
// Purpose: register-driven tests of the h-bridge drive logic
// Assumes: bus answers per hand-over latencies
// Notes: pulse and fault lines driven by the bench
`timescale 1ns/100ps
module tb_hbd_bridge_top;
  import hbd_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic              s_axi_arvalid = 0, s_axi_rready = 0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              first_pulse_line = 0, second_pulse_line = 0;
  logic              short_fault_in = 0, heat_fault_in = 0;
  logic              left_high_gate, left_low_gate, right_high_gate, right_low_gate;
  logic              fault_irq, left_output, right_output;
  int                bad_count = 0;
  int                num_checks = 0;

  hbd_bridge_top u_dut (
    .ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .first_pulse_line, .second_pulse_line, .short_fault_in, .heat_fault_in,
    .left_high_gate, .left_low_gate, .right_high_gate, .right_low_gate, .fault_irq
  );
  hbd_gate_partner u_drv (
    .left_high_gate, .left_low_gate, .right_high_gate, .right_low_gate,
    .left_output, .right_output
  );

  always #5 ref_clk = ~ref_clk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic wr(input logic [7:0] d);
    logic [1:0] r;
    axw(CSR_ADDR, d, 4'hF, r);
  endtask : wr

  task automatic rdc(input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(CSR_ADDR, d, r);
    cmp(d, {24'h0, e});
  endtask : rdc

  // gates settle within a few edges of the last change
  task automatic gchk(input logic [3:0] e);
    repeat (4) @(posedge ref_clk);
    #1;
    cmp({28'h0, left_high_gate, left_low_gate, right_high_gate, right_low_gate}, {28'h0, e});
  endtask : gchk

  task automatic ick(input logic e);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp({31'h0, fault_irq}, {31'h0, e});
  endtask : ick

  task automatic pl(input logic a, input logic b);
    @(posedge ref_clk);
    first_pulse_line  <= a;
    second_pulse_line <= b;
  endtask : pl

  // gates {lh, ll, rh, rl} for a pulse-drive mode
  function automatic logic [3:0] eg(input logic [1:0] m, input logic d, input logic a,
                                    input logic b);
    case (m)
      2'h0: eg = a ? (d ? 4'h6 : 4'h9) : 4'hA;
      2'h1: eg = a ? (d ? 4'h6 : 4'h9) : 4'h5;
      2'h2: eg = (a == !d) ? 4'h9 : 4'h6;
      default: eg = {a, !a, b, !b};
    endcase
  endfunction : eg

  initial begin : main
    logic [31:0] d;
    logic [1:0]  r;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rdc(8'h00);
    axr(8'h10, d, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    cmp(d, 32'h0);
    axw(8'h10, 8'h05, 4'hF, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    axw(CSR_ADDR, 8'h01, 4'hE, r);
    rdc(8'h00);
    wr(8'h9E);
    gchk(4'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr({4'h1, i[0], i[1], 2'b01});
      pl(i[1], i[0]);
      gchk({i[1], !i[1], i[0], !i[0]});
      cmp({30'h0, left_output, right_output}, {30'h0, i[1], i[0]});
    end
    $display("test direct done");
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 2; j++) begin
        wr({3'h0, j[0], i[0], i[1], 2'b11});
        pl(1'b0, 1'b0);
        pl(1'b1, 1'b0);
        for (int k = 0; k < 2; k++) begin
          pl(k[0], !k[0]);
          gchk(eg(i[1:0], j[0], k[0], !k[0]));
        end
      end
    end
    $display("test pulse modes done");
    wr(8'h03);
    pl(1'b0, 1'b0);
    pl(1'b1, 1'b0);
    gchk(4'h9);
    wr(8'h13);
    gchk(4'h9);
    pl(1'b0, 1'b0);
    gchk(4'hA);
    pl(1'b1, 1'b0);
    gchk(4'h6);
    wr(8'h0F);
    pl(1'b1, 1'b1);
    wr(8'h03);
    gchk(4'h9);
    $display("test direction done");
    wr(8'hE1);
    rdc(8'h81);
    wr(8'h85);
    gchk(4'h9);
    @(posedge ref_clk);
    short_fault_in <= 1'b1;
    gchk(4'h0);
    ick(1'b1);
    rdc(8'hA5);
    wr(8'h85);
    gchk(4'h0);
    @(posedge ref_clk);
    short_fault_in <= 1'b0;
    wr(8'h00);
    rdc(8'h00);
    ick(1'b0);
    wr(8'h05);
    heat_fault_in <= 1'b1;
    gchk(4'h0);
    rdc(8'h45);
    ick(1'b0);
    wr(8'h85);
    ick(1'b1);
    @(posedge ref_clk);
    heat_fault_in <= 1'b0;
    wr(8'h00);
    ick(1'b0);
    $display("test faults done");
    summarize();
  end

  initial begin : watchdog
    #200000;
    bad_count++;
    summarize();
  end
endmodule : tb_hbd_bridge_top

bind hbd_bridge_top hbd_bridge_checker u_chk (
  .ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .short_fault_in, .heat_fault_in,
  .left_high_gate, .left_low_gate, .right_high_gate, .right_low_gate, .fault_irq
);
